// ===== hb_pkg.sv
// Shared constants and types of the high-band LSP interpolator.
`default_nettype none
package hb_pkg;
    // ------------------------------------------------------------------
    // Number format
    // ------------------------------------------------------------------
    localparam int w  = 24;                 // Signed sample width.
    localparam int fb = 14;                 // Fraction bits, Q14.

    typedef logic signed [w-1:0] sample_t;
    typedef sample_t lsp_vec_t [10];
    typedef sample_t lpc_vec_t [11];
    typedef sample_t pol_t [6];

    typedef enum logic [1:0] {
        rate_13k2 = 2'h0,
        rate_16k4 = 2'h1,
        rate_24k4 = 2'h2,
        rate_32k  = 2'h3
    } rate_t;

    typedef enum logic [2:0] {
        coder_type_unvoiced   = 3'h0,
        coder_type_voiced     = 3'h1,
        coder_type_general    = 3'h2,
        coder_type_transition = 3'h3,
        coder_type_music      = 3'h4,
        coder_type_inactive   = 3'h5
    } coder_t;

    // ------------------------------------------------------------------
    // Constants in Q14
    // ------------------------------------------------------------------
    localparam sample_t one     = 24'h004000; // 1.0
    localparam sample_t half    = 24'h002000; // 0.5
    localparam sample_t quarter = 24'h001000; // 0.25
    localparam sample_t f_min   = 24'h000100; // 1/64, floor of 1-k*k.
    localparam sample_t two_pi  = 24'h019220; // 6.2832
    localparam sample_t cos_c4  = 24'h0002ab; // 1/24
    localparam sample_t cos_c6  = 24'h000017; // 1/720
    localparam sample_t tilt_c2 = 24'h01ac85; // 6.6956
    localparam sample_t tilt_c1 = 24'h00f7c5; // 3.8714
    localparam sample_t tilt_c0 = 24'h005376; // 1.3041
    localparam sample_t tilt_hi = 24'h014000; // 5.0
    localparam sample_t tilt_md = 24'h00c000; // 3.0
    localparam sample_t tilt_lo = 24'h004000; // 1.0
    localparam sample_t prev_set_weight [4] =
        '{24'h002ccd, 24'h00199a, 24'h000666, 24'h000000};
    localparam sample_t curr_set_weight [4] =
        '{24'h001333, 24'h002666, 24'h00399a, 24'h004000};

    // ------------------------------------------------------------------
    // Sequencing counts
    // ------------------------------------------------------------------
    localparam logic [3:0] order_n  = 4'ha;  // Prediction order N.
    localparam logic [3:0] lsp_last = 4'h9;  // Last LSP index.
    localparam logic [3:0] lsf_top  = 4'hc;  // Top search bit, below 0.5.
    localparam logic [1:0] set_last = 2'h3;  // Last of four sets.
    localparam logic [5:0] div_steps = 6'h26; // w+fb quotient bits.
endpackage
`default_nettype wire

// ===== div_if.sv
// Request and answer signals between the interpolator and its divider.
`timescale 1ns/1ps
`default_nettype none
interface div_if;
    logic                  start;
    logic [hb_pkg::w-1:0]  num;
    logic [hb_pkg::w-1:0]  den;
    logic                  done;
    logic [hb_pkg::w-1:0]  quot;
    modport client (output start, output num, output den,
                    input done, input quot);
    modport server (input start, input num, input den,
                    output done, output quot);
endinterface
`default_nettype wire

// ===== lsp_divider.sv
// Sequential restoring divider giving num/den in Q14.
`timescale 1ns/1ps
`default_nettype none
module lsp_divider (
    input  wire logic mclk,
    input  wire logic srst,
    div_if.server     bus
);
    localparam int dw = hb_pkg::w + hb_pkg::fb;

    logic [dw-1:0]        dvd_ff;
    logic [dw-1:0]        quo_ff;
    logic [hb_pkg::w:0]   rem_ff;
    logic [hb_pkg::w:0]   den_ff;
    logic [5:0]           cnt_ff;
    logic                 busy_ff;
    logic                 done_ff;
    logic [hb_pkg::w:0]   rem_sh;

    // Next partial remainder brings in one dividend bit.
    assign rem_sh = {rem_ff[hb_pkg::w-1:0], dvd_ff[dw-1]};

    // One quotient bit per cycle; a start while busy is ignored.
    always_ff @(posedge mclk) begin
        if (srst) begin
            dvd_ff  <= '0;
            quo_ff  <= '0;
            rem_ff  <= '0;
            den_ff  <= '0;
            cnt_ff  <= 6'h00;
            busy_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (!busy_ff && bus.start) begin
                dvd_ff  <= {bus.num, {hb_pkg::fb{1'b0}}};
                den_ff  <= {1'b0, bus.den};
                rem_ff  <= '0;
                quo_ff  <= '0;
                cnt_ff  <= hb_pkg::div_steps;
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                if (rem_sh >= den_ff) begin
                    rem_ff <= rem_sh - den_ff;
                    quo_ff <= {quo_ff[dw-2:0], 1'b1};
                end else begin
                    rem_ff <= rem_sh;
                    quo_ff <= {quo_ff[dw-2:0], 1'b0};
                end
                dvd_ff <= {dvd_ff[dw-2:0], 1'b0};
                cnt_ff <= cnt_ff - 6'h01;
                if (cnt_ff == 6'h01) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                end
            end
        end
    end

    // Callers keep quotients below 512, so the low bits are exact.
    assign bus.quot = quo_ff[hb_pkg::w-1:0];
    assign bus.done = done_ff;
endmodule
`default_nettype wire

// ===== highband_lsp_interpolator.sv
// High-band LSP interpolation with similarity-checked weights.
// Notes on behaviour
// - Similarity weights only at 13.2/16.4 kbps.
// - Top reflection coefficient is negated last coefficient.
// - Step order down: divide by one minus k squared.
// - Tilt is quadratic in one plus first reflection.
// - Transition frame means similarity not satisfied.
// - Old tilt over 5 with transient or low tilt.
// - Old tilt under 3, voiced-like old type, new over 5.
// - Otherwise non-transition and similarity satisfied.
// - Adaptive weight is smaller difference over larger.
// - End differences 0.5, inner ones adjacent LSF gaps.
// - No similarity gives constant weights 0.5.
// - Blend previous and current LSPs by selected weight.
// - Low rates: one vector to LSF and LPC.
// - High rates: four sets with fixed weights.
// - Each set to LSF and eleven LPC, first one.
`timescale 1ns/1ps
`default_nettype none
module highband_lsp_interpolator (
    input  wire logic           mclk,
    input  wire logic           srst,
    input  wire logic           start,
    input  wire hb_pkg::rate_t  rate,
    input  wire hb_pkg::coder_t coder_type,
    input  wire hb_pkg::sample_t lpc_in [10],
    input  wire hb_pkg::sample_t lsf_in [10],
    input  wire hb_pkg::sample_t lsp_in [10],
    output logic                busy,
    output logic                done,
    output logic                similar,
    output var hb_pkg::sample_t tilt,
    output var hb_pkg::sample_t lsf_out [4][10],
    output var hb_pkg::sample_t lpc_out [4][11]
);
    // ------------------------------------------------------------------
    // Arithmetic helpers
    // ------------------------------------------------------------------
    function automatic hb_pkg::sample_t mulq(input hb_pkg::sample_t x,
                                             input hb_pkg::sample_t y);
        logic signed [2*hb_pkg::w-1:0] p;
        p = x * y;
        return p[hb_pkg::fb +: hb_pkg::w];
    endfunction

    // Cosine of 2*pi*f for f in [0, 0.5]; folded so the series stays short.
    function automatic hb_pkg::sample_t cosq(input hb_pkg::sample_t f);
        hb_pkg::sample_t ff;
        hb_pkg::sample_t u;
        hb_pkg::sample_t s;
        ff = (f > hb_pkg::quarter) ? hb_pkg::half - f : f;
        u  = mulq(mulq(hb_pkg::two_pi, ff), mulq(hb_pkg::two_pi, ff));
        s  = hb_pkg::one + mulq(u, mulq(u, hb_pkg::cos_c4
             - mulq(u, hb_pkg::cos_c6)) - hb_pkg::half);
        return (f > hb_pkg::quarter) ? -s : s;
    endfunction

    // Product of second-order factors over every other LSP.
    function automatic hb_pkg::pol_t lsp_pol(input hb_pkg::lsp_vec_t q,
                                             input int off);
        hb_pkg::pol_t    f;
        hb_pkg::sample_t b;
        f    = '{default: '0};
        f[0] = hb_pkg::one;
        f[1] = -(q[off] <<< 1);
        for (int i = 2; i < 6; i++) begin
            b    = -(q[off + 2*i - 2] <<< 1);
            f[i] = mulq(b, f[i-1]) + (f[i-2] <<< 1);
            for (int j = i - 1; j > 1; j--) begin
                f[j] = f[j] + mulq(b, f[j-1]) + f[j-2];
            end
            f[1] = f[1] + b;
        end
        return f;
    endfunction

    // LSP set to eleven prediction coefficients, the first fixed at one.
    function automatic hb_pkg::lpc_vec_t lsp2lpc(input hb_pkg::lsp_vec_t q);
        hb_pkg::pol_t     f1;
        hb_pkg::pol_t     f2;
        hb_pkg::lpc_vec_t a;
        f1 = lsp_pol(q, 0);
        f2 = lsp_pol(q, 1);
        for (int i = 5; i > 0; i--) begin
            f1[i] = f1[i] + f1[i-1];
            f2[i] = f2[i] - f2[i-1];
        end
        a[0] = hb_pkg::one;
        for (int i = 1; i < 6; i++) begin
            a[i]    = (f1[i] + f2[i]) >>> 1;
            a[11-i] = (f1[i] - f2[i]) >>> 1;
        end
        return a;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [10:0] {
        st_idle     = 11'h001,
        st_refl     = 11'h002,
        st_refl_div = 11'h004,
        st_refl_upd = 11'h008,
        st_tilt     = 11'h010,
        st_class    = 11'h020,
        st_wgt      = 11'h040,
        st_wgt_div  = 11'h080,
        st_interp   = 11'h100,
        st_search   = 11'h200,
        st_lpc      = 11'h400
    } state_t;

    state_t          state_ff;
    logic [3:0]      ord_ff;
    logic [3:0]      k_ff;
    logic [3:0]      bit_ff;
    logic [1:0]      set_ff;
    logic            busy_ff;
    logic            done_ff;
    logic            similar_ff;
    logic            div_start_ff;
    hb_pkg::sample_t div_num_ff;
    hb_pkg::sample_t div_den_ff;
    hb_pkg::rate_t   rate_ff;
    hb_pkg::coder_t  coder_ff;
    hb_pkg::coder_t  prev_coder_ff;
    hb_pkg::sample_t refl_ff;
    hb_pkg::sample_t inv_f_ff;
    hb_pkg::sample_t tilt_ff;
    hb_pkg::sample_t prev_tilt_ff;
    hb_pkg::sample_t acc_ff;
    hb_pkg::sample_t a_ff [10];
    hb_pkg::sample_t lsf_ff [10];
    hb_pkg::sample_t lsp_ff [10];
    hb_pkg::sample_t prev_lsf_ff [10];
    hb_pkg::sample_t prev_lsp_ff [10];
    hb_pkg::sample_t w_ff [10];
    hb_pkg::sample_t ilsp_ff [10];
    hb_pkg::sample_t lsf_out_ff [4][10];
    hb_pkg::sample_t lpc_out_ff [4][11];

    hb_pkg::sample_t refl_now;
    hb_pkg::sample_t f_now;
    hb_pkg::sample_t x_now;
    hb_pkg::sample_t tilt_now;
    hb_pkg::sample_t dnew;
    hb_pkg::sample_t dold;
    hb_pkg::sample_t wnum;
    hb_pkg::sample_t wden;
    hb_pkg::sample_t trial;
    hb_pkg::sample_t acc_next;
    logic [3:0]      km1;
    logic            low_rate;
    logic            trans;
    logic            last_set;

    div_if div_bus ();

    lsp_divider u_div (
        .mclk (mclk),
        .srst (srst),
        .bus  (div_bus)
    );

    assign div_bus.start = div_start_ff;
    assign div_bus.num   = div_num_ff;
    assign div_bus.den   = div_den_ff;

    // ------------------------------------------------------------------
    // Combinational datapath
    // ------------------------------------------------------------------
    // Recursion step, tilt, frame class, weight operands and LSF search.
    always_comb begin
        low_rate = (rate_ff == hb_pkg::rate_13k2) ||
                   (rate_ff == hb_pkg::rate_16k4);
        last_set = low_rate || (set_ff == hb_pkg::set_last);
        refl_now = -a_ff[ord_ff - 4'h1];
        f_now    = hb_pkg::one - mulq(refl_now, refl_now);
        x_now    = hb_pkg::one - a_ff[0];
        tilt_now = mulq(hb_pkg::tilt_c2, mulq(x_now, x_now))
                   - mulq(hb_pkg::tilt_c1, x_now) + hb_pkg::tilt_c0;
        trans = (prev_tilt_ff > hb_pkg::tilt_hi &&
                 (coder_ff == hb_pkg::coder_type_transition ||
                  tilt_ff < hb_pkg::tilt_lo)) ||
                (prev_tilt_ff < hb_pkg::tilt_md &&
                 (prev_coder_ff == hb_pkg::coder_type_voiced ||
                  prev_coder_ff == hb_pkg::coder_type_general ||
                  prev_coder_ff == hb_pkg::coder_type_transition ||
                  prev_coder_ff == hb_pkg::coder_type_music) &&
                 tilt_ff > hb_pkg::tilt_hi);
        km1  = (k_ff == 4'h0) ? 4'h0 : k_ff - 4'h1;
        dnew = (k_ff == 4'h0 || k_ff == hb_pkg::lsp_last) ? hb_pkg::half
               : lsf_ff[k_ff] - lsf_ff[km1];
        dold = (k_ff == 4'h0 || k_ff == hb_pkg::lsp_last) ? hb_pkg::half
               : prev_lsf_ff[k_ff] - prev_lsf_ff[km1];
        wnum = (dnew < dold) ? dnew : dold;
        wden = (dnew < dold) ? dold : dnew;
        trial    = acc_ff | hb_pkg::sample_t'(24'h000001 << bit_ff);
        acc_next = (cosq(trial) >= ilsp_ff[k_ff]) ? trial : acc_ff;
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Walks recursion, weights and sets; starts are ignored while busy.
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_ff     <= st_idle;
            ord_ff       <= 4'h0;
            k_ff         <= 4'h0;
            bit_ff       <= 4'h0;
            set_ff       <= 2'h0;
            busy_ff      <= 1'b0;
            done_ff      <= 1'b0;
            div_start_ff <= 1'b0;
            div_num_ff   <= '0;
            div_den_ff   <= '0;
        end else begin
            done_ff      <= 1'b0;
            div_start_ff <= 1'b0;
            case (state_ff)
                st_idle: if (start) begin
                    ord_ff   <= hb_pkg::order_n;
                    busy_ff  <= 1'b1;
                    state_ff <= st_refl;
                end
                st_refl: begin
                    // An unstable step would blow up 1/F, so F is floored.
                    div_start_ff <= 1'b1;
                    div_num_ff   <= hb_pkg::one;
                    div_den_ff   <= (f_now < hb_pkg::f_min) ? hb_pkg::f_min
                                    : f_now;
                    state_ff     <= st_refl_div;
                end
                st_refl_div: if (div_bus.done) begin
                    state_ff <= st_refl_upd;
                end
                st_refl_upd: if (ord_ff == 4'h2) begin
                    state_ff <= st_tilt;
                end else begin
                    ord_ff   <= ord_ff - 4'h1;
                    state_ff <= st_refl;
                end
                st_tilt: state_ff <= st_class;
                st_class: begin
                    k_ff     <= 4'h0;
                    set_ff   <= 2'h0;
                    state_ff <= low_rate ? st_wgt : st_interp;
                end
                st_wgt: if (similar_ff && wden > 0) begin
                    div_start_ff <= 1'b1;
                    div_num_ff   <= (wnum < 0) ? '0 : wnum;
                    div_den_ff   <= wden;
                    state_ff     <= st_wgt_div;
                end else if (k_ff == hb_pkg::lsp_last) begin
                    state_ff <= st_interp;
                end else begin
                    k_ff <= k_ff + 4'h1;
                end
                st_wgt_div: if (div_bus.done) begin
                    if (k_ff == hb_pkg::lsp_last) begin
                        state_ff <= st_interp;
                    end else begin
                        k_ff     <= k_ff + 4'h1;
                        state_ff <= st_wgt;
                    end
                end
                st_interp: begin
                    k_ff     <= 4'h0;
                    bit_ff   <= hb_pkg::lsf_top;
                    state_ff <= st_search;
                end
                st_search: if (bit_ff == 4'h0) begin
                    bit_ff <= hb_pkg::lsf_top;
                    if (k_ff == hb_pkg::lsp_last) begin
                        state_ff <= st_lpc;
                    end else begin
                        k_ff <= k_ff + 4'h1;
                    end
                end else begin
                    bit_ff <= bit_ff - 4'h1;
                end
                st_lpc: if (!last_set) begin
                    set_ff   <= set_ff + 2'h1;
                    state_ff <= st_interp;
                end else begin
                    busy_ff  <= 1'b0;
                    done_ff  <= 1'b1;
                    state_ff <= st_idle;
                end
                default: state_ff <= st_idle;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Frame capture, reflection recursion, tilt and class
    // ------------------------------------------------------------------
    // The whole order-p update happens in one cycle from the old vector,
    // which avoids a scratch copy for the mirrored reads.
    always_ff @(posedge mclk) begin
        if (srst) begin
            rate_ff    <= hb_pkg::rate_13k2;
            coder_ff   <= hb_pkg::coder_type_unvoiced;
            refl_ff    <= '0;
            inv_f_ff   <= '0;
            tilt_ff    <= '0;
            similar_ff <= 1'b0;
            a_ff       <= '{default: '0};
            lsf_ff     <= '{default: '0};
            lsp_ff     <= '{default: '0};
        end else begin
            if (state_ff == st_idle && start) begin
                rate_ff  <= rate;
                coder_ff <= coder_type;
                a_ff     <= lpc_in;
                lsf_ff   <= lsf_in;
                lsp_ff   <= lsp_in;
            end
            if (state_ff == st_refl) begin
                refl_ff <= refl_now;
            end
            if (state_ff == st_refl_div && div_bus.done) begin
                inv_f_ff <= div_bus.quot;
            end
            if (state_ff == st_refl_upd) begin
                for (int m = 1; m < 10; m++) begin
                    if (m < int'(ord_ff)) begin
                        a_ff[m-1] <= mulq(a_ff[m-1] - mulq(refl_ff,
                            a_ff[4'(int'(ord_ff) - m - 1)]), inv_f_ff);
                    end
                end
            end
            if (state_ff == st_tilt) begin
                tilt_ff <= tilt_now;
            end
            if (state_ff == st_class) begin
                similar_ff <= !trans;
            end
        end
    end

    // ------------------------------------------------------------------
    // Weights, blending and LSF search
    // ------------------------------------------------------------------
    // Equal zero gaps count as identical, so their weight is one.
    always_ff @(posedge mclk) begin
        if (srst) begin
            w_ff    <= '{default: '0};
            ilsp_ff <= '{default: '0};
            acc_ff  <= '0;
        end else begin
            if (state_ff == st_wgt && !similar_ff) begin
                w_ff[k_ff] <= hb_pkg::half;
            end else if (state_ff == st_wgt && wden <= 0) begin
                w_ff[k_ff] <= hb_pkg::one;
            end
            if (state_ff == st_wgt_div && div_bus.done) begin
                w_ff[k_ff] <= div_bus.quot;
            end
            if (state_ff == st_interp) begin
                for (int i = 0; i < 10; i++) begin
                    ilsp_ff[i] <= low_rate
                        ? mulq(hb_pkg::one - w_ff[i], prev_lsp_ff[i])
                          + mulq(w_ff[i], lsp_ff[i])
                        : mulq(hb_pkg::prev_set_weight[set_ff],
                               prev_lsp_ff[i])
                          + mulq(hb_pkg::curr_set_weight[set_ff],
                                 lsp_ff[i]);
                end
                acc_ff <= '0;
            end
            if (state_ff == st_search) begin
                acc_ff <= (bit_ff == 4'h0) ? '0 : acc_next;
            end
        end
    end

    // ------------------------------------------------------------------
    // Output sets
    // ------------------------------------------------------------------
    // Low rates only ever write set 0; other sets keep older contents.
    always_ff @(posedge mclk) begin
        if (srst) begin
            lsf_out_ff <= '{default: '{default: '0}};
            lpc_out_ff <= '{default: '{default: '0}};
        end else begin
            if (state_ff == st_search && bit_ff == 4'h0) begin
                lsf_out_ff[set_ff][k_ff] <= acc_next;
            end
            if (state_ff == st_lpc) begin
                lpc_out_ff[set_ff] <= lsp2lpc(ilsp_ff);
            end
        end
    end

    // ------------------------------------------------------------------
    // Previous-frame memory
    // ------------------------------------------------------------------
    // Updated once the last set is out, so it never feeds its own frame.
    always_ff @(posedge mclk) begin
        if (srst) begin
            prev_lsp_ff   <= '{default: '0};
            prev_lsf_ff   <= '{default: '0};
            prev_tilt_ff  <= '0;
            prev_coder_ff <= hb_pkg::coder_type_unvoiced;
        end else if (state_ff == st_lpc && last_set) begin
            prev_lsp_ff   <= lsp_ff;
            prev_lsf_ff   <= lsf_ff;
            prev_tilt_ff  <= tilt_ff;
            prev_coder_ff <= coder_ff;
        end
    end

    assign busy    = busy_ff;
    assign done    = done_ff;
    assign similar = similar_ff;
    assign tilt    = tilt_ff;
    assign lsf_out = lsf_out_ff;
    assign lpc_out = lpc_out_ff;
endmodule
`default_nettype wire

// ===== hlsp_monitor.sv
// Concurrent checks on the interpolator's ports.
`timescale 1ns/1ps
`default_nettype none
module hlsp_monitor (
    input wire logic            mclk,
    input wire logic            srst,
    input wire logic            start,
    input wire hb_pkg::rate_t   rate,
    input wire logic            busy,
    input wire logic            done,
    input wire hb_pkg::sample_t tilt,
    input wire hb_pkg::sample_t lpc_out [4][11]
);
    // ----------------------------------------------------------------
    // Frame handshake and result properties
    // ----------------------------------------------------------------
    // One domain, so clock and reset are given once for all.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    logic hi_rate_ff;
    // Rate of the frame in flight; the rate port may already carry the
    // next frame's rate by the time done is seen.
    always_ff @(posedge mclk) begin
        if (srst) hi_rate_ff <= 1'b0;
        else if (start && !busy) hi_rate_ff <= rate[1];
    end
    a_start_taken: assert property (start && !busy |=> busy)
        else $error("start not taken");
    a_frame_bound: assert property (start && !busy |-> ##[300:1000] done)
        else $error("frame too long");
    a_done_pulse: assert property (done |-> !busy ##1 !done)
        else $error("done not a pulse");
    a_idle_holds: assert property (!busy && !start |=> !busy)
        else $error("frame began unasked");
    a_tilt_held: assert property (!busy |=> $stable(tilt))
        else $error("tilt moved while idle");
    a_lead_one: assert property (done |-> lpc_out[0][0] == hb_pkg::one)
        else $error("first coefficient not one");
    a_four_sets: assert property (done && hi_rate_ff |->
        lpc_out[3][0] == hb_pkg::one)
        else $error("fourth set missing");
    // Reset is checked with the disable lifted, as it is the cause here.
    a_reset_clr: assert property (disable iff (1'b0)
        srst |=> !busy && !done && tilt == '0)
        else $error("reset left state");
endmodule
bind highband_lsp_interpolator hlsp_monitor hlsp_monitor_inst (
    .mclk(mclk), .srst(srst), .start(start), .rate(rate), .busy(busy),
    .done(done), .tilt(tilt), .lpc_out(lpc_out));
`default_nettype wire

// ===== frame_source.sv
// Model of the encoder datapath that supplies LSFs and LSPs.
`timescale 1ns/1ps
`default_nettype none
module frame_source (
    input  wire logic [31:0]    seed,
    output var hb_pkg::sample_t lsf [10],
    output var hb_pkg::sample_t lsp [10]
);
    // Ascending LSFs below 0.5; the step exceeds the jitter so the
    // order never inverts. Each LSP is the cosine of its LSF.
    always_comb begin
        for (int k = 0; k < 10; k++) begin
            lsf[k] = 24'(k * 700 + 400 + ((seed >> k) & 32'hff));
            lsp[k] = 24'($rtoi(16384.0 * $cos(6.2831853 * lsf[k] / 16384.0)));
        end
    end
endmodule
`default_nettype wire

// ===== highband_lsp_interpolator_test.sv
// Self-checking bench for the high-band LSP interpolator.
`timescale 1ns/1ps
`default_nettype none
module highband_lsp_interpolator_test;
    logic            mclk = 0, srst = 1, start = 0, busy, done, similar;
    hb_pkg::rate_t   rate = hb_pkg::rate_13k2;
    hb_pkg::coder_t  coder_type = hb_pkg::coder_type_unvoiced;
    hb_pkg::sample_t lpc_in [10] = '{default: '0}, lsf_in [10], lsp_in [10];
    hb_pkg::sample_t tilt, lsf_out [4][10], lpc_out [4][11];
    logic [31:0]     rnd = 32'h6d1b7b51;
    int              n_fail = 0, n_checks = 0, pc = 0, a;
    int              pl [10] = '{default: 0}, pp [10] = '{default: 0};
    real             pt = 0.0;
    // ----------------------------------------------------------------
    // Clock, design and partner
    // ----------------------------------------------------------------
    always #5 mclk = ~mclk;
    highband_lsp_interpolator highband_lsp_interpolator_inst (.mclk, .srst,
        .start, .rate, .coder_type, .lpc_in, .lsf_in, .lsp_in, .busy,
        .done, .similar, .tilt, .lsf_out, .lpc_out);
    frame_source frame_source_inst (.seed(rnd), .lsf(lsf_in), .lsp(lsp_in));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic cmp(input hb_pkg::sample_t g, input int e, input int tol);
        n_checks++;
        if ($isunknown(g) || int'(g) - e > tol || e - int'(g) > tol) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, 24'(e));
        end
    endtask
    // The model keeps the previous tilt and coder type as the design
    // should; a tilt table keeps every frame clear of the thresholds.
    task automatic frame(input int f);
        real x, t, w, e;
        logic tr;
        int i, dn, d0;
        rnd = xs(rnd);
        rate = hb_pkg::rate_t'(rnd[1:0]);
        coder_type = hb_pkg::coder_t'(3'(rnd[4:2] % 6));
        a = rnd[6:5] == 0 ? 11469 : rnd[6:5] == 1 ? 0 :
            rnd[6:5] == 2 ? -3277 : 4915;
        lpc_in[0] = 24'(a);
        start = 1;
        @(posedge mclk) #1 start = 0;
        i = 0;
        while (done !== 1'b1 && i < 1100) begin
            @(posedge mclk) #1 i++;
        end
        cmp(24'(done), 1, 0);
        x = 1.0 - a / 16384.0;
        t = 6.6956 * x * x - 3.8714 * x + 1.3041;
        tr = (pt > 5.0 && (coder_type == 3 || t < 1.0)) ||
             (pt < 3.0 && pc inside {[1:4]} && t > 5.0);
        cmp(24'(similar), 32'(!tr), 0);
        cmp(tilt, $rtoi(t * 16384.0), 64);
        for (int s = 0; s < (rate[1] ? 4 : 1); s++) begin
            cmp(lpc_out[s][0], 16384, 0);
            for (int k = 0; k < 10; k++) begin
                dn = k % 9 == 0 ? 8192 : lsf_in[k] - lsf_in[(k + 9) % 10];
                d0 = k % 9 == 0 ? 8192 : pl[k] - pl[(k + 9) % 10];
                w = rate[1] ? (s == 3 ? 1.0 : 0.3 * (s + 1)) : tr ? 0.5 :
                    dn < d0 ? 1.0 * dn / d0 : dn > 0 ? 1.0 * d0 / dn : 1.0;
                e = (1.0 - w) * pp[k] + w * lsp_in[k];
                e = $acos(e / 16384.0) / 6.2831853 * 16384.0;
                cmp(lsf_out[s][k], $rtoi(e), 64);
            end
        end
        pt = t;
        pc = coder_type;
        foreach (pl[k]) begin
            pl[k] = lsf_in[k];
            pp[k] = lsp_in[k];
        end
        $display("frame %0d rate %0d similar %b", f, rate, similar);
    endtask
    task automatic print_verdict();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Reset for four cycles, then frames back to back at random rates.
    initial begin
        repeat (4) @(posedge mclk);
        #1 srst = 0;
        for (int f = 0; f < 24; f++) frame(f);
        print_verdict();
    end
    // Watchdog: 24 frames take under 25000 cycles.
    initial begin
        #400000 n_fail++;
        print_verdict();
    end
endmodule
`default_nettype wire
